// >>> core/cap_regs_consts.svh
// Offsets, field positions, reset values of the converter control registers.
// Assumes inclusion by bare name from core/ and dv/ files.
`ifndef CAP_REGS_CONSTS_SVH
`define CAP_REGS_CONSTS_SVH

// Register offsets (register index on the host access port)
`define SEQ_CTRL_ADDR 8'h1B
`define RST_GAIN_ADDR 8'h1C
`define DRIVE0_ADDR 8'h1E

// Channel sequencing control fields
`define SWEEP_EN_BIT 15
`define SWEEP_ORD_HI 14
`define SWEEP_ORD_LO 13
`define SEQ_FIXED_HI 12
`define SEQ_FIXED_LO 3
`define DEGLITCH_HI 2
`define DEGLITCH_LO 0

// Software reset and gain fields
`define SW_RESET_BIT 15
`define GAIN_HI 10
`define GAIN_LO 9

// Channel 0 drive fields
`define DRIVE_HI 15
`define DRIVE_LO 11

// Reset values
`define SEQ_CTRL_RESET 16'h020F
`define RST_GAIN_RESET 16'h0000
`define DRIVE0_RESET 16'h0000

// Sweep order codes
`define ORDER_TWO_A 2'h0
`define ORDER_THREE 2'h1
`define ORDER_FOUR 2'h2
`define ORDER_TWO_B 2'h3

// Result shift amounts per gain code
`define SHIFT_GAIN1 3'h0
`define SHIFT_GAIN4 3'h2
`define SHIFT_GAIN8 3'h3
`define SHIFT_GAIN16 3'h4

`endif

// >>> core/cap_regs_pkg.sv
// Types shared by the converter control register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package cap_regs_pkg;

    // One host access on the register port
    typedef struct packed {
        logic wr;          // Write strobe, one cycle
        logic rd;          // Read strobe, one cycle
        logic [7:0] addr;  // Register offset
        logic [15:0] wdata; // Write data
    } reg_req_t;

    // Conversion scheduling mode, one-hot
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b01,
        MODE_SWEEP = 2'b10
    } scan_mode_t;

endpackage : cap_regs_pkg

// >>> core/scan_sequencer.sv
// Channel scheduler: picks the channel converted next.
// Assumes conv_done pulses once when the current conversion ends.
`include "cap_regs_consts.svh"
module scan_sequencer
    import cap_regs_pkg::*;
#(
    parameter int NUM_CHANNELS = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic sweep_en,
    input wire logic [1:0] sweep_order,
    input wire logic [1:0] single_sel,
    input wire logic restart,
    input wire logic conv_done,
    // Result
    output logic [1:0] channel_reg,
    output scan_mode_t mode_reg
);

    ////////////////////////////////////////////////////////////////////////
    // Last channel of a sweep order; small parts fall back to two channels
    function automatic logic [1:0] last_channel(input logic [1:0] order);
        logic [1:0] last;
        last = 2'h1;
        case (order)
            `ORDER_THREE: last = (NUM_CHANNELS >= 4) ? 2'h2 : 2'h1;
            `ORDER_FOUR: last = (NUM_CHANNELS >= 4) ? 2'h3 : 2'h1;
            default: last = 2'h1;
        endcase
        return last;
    endfunction

    // Single channel pick, limited to channels present
    function automatic logic [1:0] clamp_single(input logic [1:0] sel);
        return (NUM_CHANNELS >= 4) ? sel : {1'b0, sel[0]};
    endfunction

    scan_mode_t mode_next; // Mode from the enable bit

    always_comb begin
        mode_next = sweep_en ? MODE_SWEEP : MODE_SINGLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= MODE_SINGLE;
        end else begin
            mode_reg <= mode_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_reg <= 2'h0;
        end else begin
            case (mode_next)
                MODE_SINGLE: begin
                    channel_reg <= clamp_single(single_sel);
                end
                MODE_SWEEP: begin
                    // Sweep starts at channel 0 on entry or on a pattern change
                    if (restart || (mode_reg != MODE_SWEEP)) begin
                        channel_reg <= 2'h0;
                    end else if (conv_done) begin
                        // One conversion each, then wrap to first channel
                        if (channel_reg >= last_channel(sweep_order)) begin
                            channel_reg <= 2'h0;
                        end else begin
                            channel_reg <= channel_reg + 2'h1;
                        end
                    end
                end
                default: begin
                    channel_reg <= 2'h0;
                end
            endcase
        end
    end

endmodule // scan_sequencer

// >>> core/cap_sensor_mux_reset_drive_regs.sv
// Control register bank of a multi-channel capacitance converter.
// Assumes the serial host interface decodes accesses into one-cycle
// strobes on the register port, and that the converter core reports
// conversions with conv_done and conv_valid pulses.
// Assumes the host keeps reserved fields at their required values.
//
// Overview of operation
// - Sweep off: convert only selected channel.
// - Sweep on: scan in chosen order.
// - One conversion per channel, then wrap around.
// - Orders: 00/11 two, 01 three, 10 four.
// - Filter field selects deglitch bandwidth, reset 111.
// - Writing reset bit resets whole device.
// - Reset trigger bit always reads zero.
// - Gain field shifts result by 0,2,3,4.
// - Channel 0 drive code sets its current.
// - Channel select picks single converted channel.
`include "cap_regs_consts.svh"
module cap_sensor_mux_reset_drive_regs
    import cap_regs_pkg::*;
#(
    parameter int NUM_CHANNELS = 4,   // Two- or four-channel part
    parameter bit FAST_VARIANT = 1'b1, // Gain shift present
    parameter int RESULT_W = 28       // Conversion result width
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register access port
    input wire reg_req_t reg_req,
    output logic [15:0] rdata_reg,
    output logic rvalid_reg,
    // Configuration from the general configuration register
    input wire logic [1:0] single_channel_select,
    // Converter core
    input wire logic conv_done,
    input wire logic conv_valid,
    input wire logic [RESULT_W-1:0] conv_result,
    // Controls to the analog front end and core
    output logic [1:0] active_channel_reg,
    output logic [2:0] deglitch_bw_reg,
    output logic [4:0] drive_level_reg,
    output logic drive_ch0_reg,
    output logic device_reset_reg,
    // Scaled result
    output logic [RESULT_W-1:0] result_reg,
    output logic result_valid_reg
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    // Host-visible words and their write decode
    logic [15:0] seq_ctrl_reg; // Channel sequencing control
    logic [15:0] rst_gain_reg; // Software reset and gain, bit 15 unused
    logic [4:0] drive0_reg;    // Channel 0 drive code
    logic wr_seq;              // Write to sequencing control
    logic wr_rst;              // Write to reset and gain
    logic wr_drv;              // Write to channel 0 drive
    logic soft_reset;          // Software reset requested this cycle
    logic restart;             // Scan pattern changed
    logic [1:0] seq_channel;   // Channel picked by the scheduler

    ////////////////////////////////////////////////////////////////////////
    // Shift amount for a gain code
    // Codes outside the table fall back to no shift
    function automatic logic [2:0] gain_shift(input logic [1:0] code);
        logic [2:0] sh;
        sh = `SHIFT_GAIN1;
        case (code)
            2'h1: sh = `SHIFT_GAIN4;
            2'h2: sh = `SHIFT_GAIN8;
            2'h3: sh = `SHIFT_GAIN16;
            default: sh = `SHIFT_GAIN1;
        endcase
        return sh;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    // Only the three mapped offsets are decoded; others are ignored
    assign wr_seq = reg_req.wr && (reg_req.addr == `SEQ_CTRL_ADDR);
    assign wr_rst = reg_req.wr && (reg_req.addr == `RST_GAIN_ADDR);
    assign wr_drv = reg_req.wr && (reg_req.addr == `DRIVE0_ADDR);
    assign soft_reset = wr_rst && reg_req.wdata[`SW_RESET_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Restart on any change of sweep enable or order
    // A soft reset also restarts the scan from channel 0
    assign restart = soft_reset
        || (wr_seq && (reg_req.wdata[`SWEEP_EN_BIT:`SWEEP_ORD_LO]
                       != seq_ctrl_reg[`SWEEP_EN_BIT:`SWEEP_ORD_LO]));

    ////////////////////////////////////////////////////////////////////////
    // Sequencing control register; whole word kept as written
    // A soft reset wins over a write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_ctrl_reg <= `SEQ_CTRL_RESET;
        end else if (soft_reset) begin
            seq_ctrl_reg <= `SEQ_CTRL_RESET;
        end else if (wr_seq) begin
            seq_ctrl_reg <= reg_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset and gain register; trigger bit never stored
    // Gain and reserved bits read back as written
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_gain_reg <= `RST_GAIN_RESET;
        end else if (soft_reset) begin
            rst_gain_reg <= `RST_GAIN_RESET;
        end else if (wr_rst) begin
            rst_gain_reg <= {1'b0, reg_req.wdata[14:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel 0 drive register; reserved bits not stored
    // Only the code bits are kept, so bits 10:0 read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive0_reg <= 5'(`DRIVE0_RESET);
        end else if (soft_reset) begin
            drive0_reg <= 5'(`DRIVE0_RESET);
        end else if (wr_drv) begin
            drive0_reg <= reg_req.wdata[`DRIVE_HI:`DRIVE_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, answer one cycle after the strobe
    // A read in the same cycle as a write returns the old word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_req.rd;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    `SEQ_CTRL_ADDR: rdata_reg <= seq_ctrl_reg;
                    `RST_GAIN_ADDR: rdata_reg <= {1'b0, rst_gain_reg[14:0]};
                    `DRIVE0_ADDR: rdata_reg <= {drive0_reg, 11'h000};
                    default: rdata_reg <= 16'h0000; // Unmapped offsets
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel scheduler
    // Single select or sweep order decides the channel
    scan_sequencer #(
        .NUM_CHANNELS(NUM_CHANNELS)
    ) u_seq (
        .clk(clk),
        .rst_n(rst_n),
        .sweep_en(seq_ctrl_reg[`SWEEP_EN_BIT]),
        .sweep_order(seq_ctrl_reg[`SWEEP_ORD_HI:`SWEEP_ORD_LO]),
        .single_sel(single_channel_select),
        .restart(restart),
        .conv_done(conv_done),
        .channel_reg(seq_channel),
        .mode_reg()
    );

    ////////////////////////////////////////////////////////////////////////
    // Front end controls, registered at the outputs
    // Drive code is zero while another channel is converted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_channel_reg <= 2'h0;
            deglitch_bw_reg <= 3'h7;
            drive_level_reg <= 5'h00;
            drive_ch0_reg <= 1'b0;
        end else begin
            active_channel_reg <= seq_channel;
            deglitch_bw_reg <= seq_ctrl_reg[`DEGLITCH_HI:`DEGLITCH_LO];
            // Drive code applied while channel 0 settles and converts
            drive_ch0_reg <= (seq_channel == 2'h0);
            drive_level_reg <= (seq_channel == 2'h0) ? drive0_reg : 5'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Device reset pulse to the rest of the chip
    // One cycle long, in the cycle after the trigger write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            device_reset_reg <= 1'b0;
        end else begin
            device_reset_reg <= soft_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result gain; high bits shifted out are lost
    // Gain applies on the fast variant only
    // Result holds its value between valid pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= '0;
            result_valid_reg <= 1'b0;
        end else begin
            result_valid_reg <= conv_valid;
            if (conv_valid) begin
                if (FAST_VARIANT) begin
                    result_reg <= conv_result << gain_shift(rst_gain_reg[`GAIN_HI:`GAIN_LO]);
                end else begin
                    result_reg <= conv_result;
                end
            end
        end
    end

endmodule // cap_sensor_mux_reset_drive_regs

// >>> dv/cap_regs_asserts.sv
// Port checker for the converter control register bank.
// Assumes a bind onto the bank; one clock, async active-low reset.
`include "cap_regs_consts.svh"
module cap_regs_asserts
    import cap_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host port
    input wire reg_req_t reg_req,
    input wire logic [15:0] rdata_reg,
    input wire logic rvalid_reg,
    // Converter side
    input wire logic [1:0] single_channel_select,
    input wire logic conv_done,
    input wire logic conv_valid,
    input wire logic result_valid_reg,
    // Front end controls
    input wire logic [1:0] active_channel_reg,
    input wire logic [2:0] deglitch_bw_reg,
    input wire logic [4:0] drive_level_reg,
    input wire logic drive_ch0_reg,
    input wire logic device_reset_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic sweep_q; // Mirror of the sweep enable bit
    logic seq_wr; // Write to sequencing register
    logic rst_wr; // Software reset write
    logic live_q; // Set one edge after reset release
    assign seq_wr = reg_req.wr && reg_req.addr == `SEQ_CTRL_ADDR;
    assign rst_wr = reg_req.wr && reg_req.addr == `RST_GAIN_ADDR && reg_req.wdata[`SW_RESET_BIT];
    // Follow sweep enable from host writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sweep_q <= 1'h0;
        end else if (seq_wr) begin
            sweep_q <= reg_req.wdata[`SWEEP_EN_BIT];
        end else if (rst_wr) begin
            sweep_q <= 1'h0;
        end
    end
    // Outputs hold reset values until the first edge after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live_q <= 1'h0;
        end else begin
            live_q <= 1'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_reset_bit_zero: assert property ((reg_req.rd && reg_req.addr == `RST_GAIN_ADDR)
        |=> rvalid_reg && !rdata_reg[`SW_RESET_BIT]) else $error("reset bit read back set");
    a_swreset_pulse: assert property (rst_wr |=> device_reset_reg)
        else $error("no device reset pulse");
    a_swreset_quiet: assert property (!rst_wr |=> !device_reset_reg)
        else $error("device reset without trigger");
    a_result_pulse: assert property (conv_valid ##1 !conv_valid
        |-> result_valid_reg ##1 !result_valid_reg) else $error("result valid pulse wrong");
    a_drive_gated: assert property (!drive_ch0_reg |-> drive_level_reg == 5'h0)
        else $error("drive code outside channel 0");
    a_drive_ch0_on: assert property ((live_q && active_channel_reg == 2'h0) [*2] |-> drive_ch0_reg)
        else $error("channel 0 drive missing");
    a_drive_ch0_off: assert property ((active_channel_reg != 2'h0) [*2] |-> !drive_ch0_reg)
        else $error("channel 0 drive stuck");
    a_deglitch_reset: assert property ($rose(rst_n) |-> deglitch_bw_reg == 3'h7)
        else $error("deglitch reset value wrong");
    a_single_follow: assert property ((!sweep_q && !reg_req.wr && $stable(single_channel_select)) [*4]
        |-> active_channel_reg == single_channel_select) else $error("single channel not followed");
    a_sweep_restart: assert property ((seq_wr && reg_req.wdata[`SWEEP_EN_BIT] && !sweep_q)
        ##1 !conv_done [*2] |=> active_channel_reg == 2'h0) else $error("sweep not started at 0");
endmodule // cap_regs_asserts

bind cap_sensor_mux_reset_drive_regs cap_regs_asserts i_cap_regs_asserts (.clk(clk), .rst_n(rst_n),
    .reg_req(reg_req), .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg), .conv_done(conv_done),
    .single_channel_select(single_channel_select), .conv_valid(conv_valid),
    .result_valid_reg(result_valid_reg), .active_channel_reg(active_channel_reg),
    .deglitch_bw_reg(deglitch_bw_reg), .drive_level_reg(drive_level_reg),
    .drive_ch0_reg(drive_ch0_reg), .device_reset_reg(device_reset_reg));

// >>> dv/host_model.sv
// Host model: register writes and reads as one-cycle strobes.
// Assumes the bench clock; requests change just after a rising edge.
`include "cap_regs_consts.svh"
module host_model
    import cap_regs_pkg::*;
(
    // Clock
    input wire logic clk,
    // Request to the register bank
    output reg_req_t req
);
    timeunit 1ns;
    timeprecision 1ns;
    int idle = 0; // Extra quiet cycles before each request
    initial req = '0;
    // One strobe, held up to its taking edge
    task automatic issue(input logic w, input logic [7:0] a, input logic [15:0] d);
        repeat (idle) @(posedge clk);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask
    // Write with reserved fields set as the host must
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a == `SEQ_CTRL_ADDR) v[12:3] = 10'h041;
        if (a == `RST_GAIN_ADDR) v = v & 16'h8600;
        issue(1'h1, a, v);
    endtask
endmodule // host_model

// >>> dv/cap_sensor_mux_reset_drive_regs_tb.sv
// Self-checking bench for the converter control register bank.
// Assumes the host model and the bound checker compile alongside.
module cap_sensor_mux_reset_drive_regs_tb
    import cap_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0; // Bench clock
    logic rst_n = 1'h0; // Reset, active low
    reg_req_t reg_req; // Host strobes
    logic [1:0] single_channel_select = 2'h0;
    logic conv_done = 1'h0;
    logic conv_valid = 1'h0;
    logic [27:0] conv_result = 28'h0;
    logic [15:0] rdata_reg;
    logic rvalid_reg, drive_ch0_reg, device_reset_reg, result_valid_reg;
    logic [1:0] active_channel_reg;
    logic [2:0] deglitch_bw_reg;
    logic [4:0] drive_level_reg, code;
    logic [27:0] result_reg;
    logic [15:0] rd_q[$]; // Expected read data
    logic [27:0] res_q[$]; // Expected scaled results
    logic [2:0] dg[4] = '{3'h1, 3'h4, 3'h5, 3'h7}; // Legal deglitch codes only
    int sh[4] = '{0, 2, 3, 4}; // Shift per gain code
    int bad_count = 0;
    int tests_run = 0;
    int n;
    integer seed = 32'hDF5FFC02;
    always #5 clk = ~clk;
    cap_sensor_mux_reset_drive_regs i_cap_sensor_mux_reset_drive_regs (.clk(clk), .rst_n(rst_n),
        .reg_req(reg_req), .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg), .conv_done(conv_done),
        .single_channel_select(single_channel_select), .conv_valid(conv_valid), .conv_result(conv_result),
        .active_channel_reg(active_channel_reg), .deglitch_bw_reg(deglitch_bw_reg),
        .drive_level_reg(drive_level_reg), .drive_ch0_reg(drive_ch0_reg), .device_reset_reg(device_reset_reg),
        .result_reg(result_reg), .result_valid_reg(result_valid_reg));
    host_model i_host_model (.clk(clk), .req(reg_req));
    ////////////////////////////////////////////////////////////////////////////
    // Count one comparison, report a mismatch
    task automatic check(input string what, input logic [27:0] exp, input logic [27:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Note the answer, then read
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        rd_q.push_back(exp);
        i_host_model.issue(1'h0, a, 16'h0000);
    endtask
    // Let updates land
    task automatic wait_cycles(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // One conversion finished
    task automatic pulse_done;
        @(posedge clk);
        conv_done <= 1'h1;
        @(posedge clk);
        conv_done <= 1'h0;
    endtask
    // One raw result, scaled value noted
    task automatic send_result(input logic [27:0] r, input int s);
        res_q.push_back(r << s);
        @(posedge clk);
        conv_valid <= 1'h1;
        conv_result <= r;
        @(posedge clk);
        conv_valid <= 1'h0;
    endtask
    // Verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Compare answers against the oldest notes
    always @(posedge clk) begin
        if (rvalid_reg === 1'h1) check("rdata", rd_q.size() > 0 ? 28'(rd_q.pop_front()) : 28'hX, 28'(rdata_reg));
        if (result_valid_reg === 1'h1) check("result", res_q.size() > 0 ? res_q.pop_front() : 28'hX, result_reg);
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        // Reset values, unmapped offset
        rd(8'h1B, 16'h020F);
        rd(8'h1C, 16'h0000);
        rd(8'h1E, 16'h0000);
        rd(8'h1D, 16'h0000);
        // Drive code: top value, then random; reserved bits read zero
        for (int i = 0; i < 2; i++) begin
            code = (i == 0) ? 5'h1F : 5'($random(seed));
            i_host_model.write(8'h1E, {code, 11'h7FF});
            rd(8'h1E, {code, 11'h000});
            for (int c = 0; c < 4; c++) begin
                @(posedge clk);
                single_channel_select <= 2'(c);
                wait_cycles(4);
                check("single_chan", 28'(c), 28'(active_channel_reg));
                check("drive", (c == 0) ? 28'(code) : 28'h0, 28'(drive_level_reg));
                check("drive_ch0", (c == 0) ? 28'h1 : 28'h0, 28'(drive_ch0_reg));
            end
        end
        pulse_done;
        wait_cycles(3);
        check("single_hold", 28'h3, 28'(active_channel_reg));
        // Every sweep order, each with one of four deglitch codes
        for (int o = 0; o < 4; o++) begin
            n = (o == 1) ? 3 : (o == 2) ? 4 : 2;
            i_host_model.write(8'h1B, {1'h1, 2'(o), 10'h041, dg[o]});
            wait_cycles(3);
            check("deglitch", 28'(dg[o]), 28'(deglitch_bw_reg));
            for (int k = 0; k < 2 * n + 1; k++) begin
                check("sweep_chan", 28'(k % n), 28'(active_channel_reg));
                pulse_done;
                wait_cycles(2);
            end
        end
        // Every gain code, random and full-scale results
        for (int g = 0; g < 4; g++) begin
            i_host_model.idle = g % 2;
            i_host_model.write(8'h1C, {5'h00, 2'(g), 9'h000});
            rd(8'h1C, {5'h00, 2'(g), 9'h000});
            wait_cycles(2);
            send_result(28'($random(seed)), sh[g]);
            send_result(28'hFFFFFFF, sh[g]);
        end
        // Software reset returns registers to reset values
        i_host_model.write(8'h1E, 16'hF800);
        i_host_model.write(8'h1C, 16'h8600);
        #1;
        check("dev_reset", 28'h1, 28'(device_reset_reg));
        rd(8'h1C, 16'h0000);
        rd(8'h1B, 16'h020F);
        rd(8'h1E, 16'h0000);
        wait_cycles(1);
        check("reset_chan", 28'h3, 28'(active_channel_reg));
        for (int t = 0; t < 20 && rd_q.size() + res_q.size() > 0; t++) @(posedge clk);
        if (rd_q.size() + res_q.size() > 0) bad_count++;
        complete_run;
    end
endmodule // cap_sensor_mux_reset_drive_regs_tb
